/* logic/plct_defs.vh */
// Purpose: offsets, field positions, reset values and timing for the pulse/length/timer block
// Assumes: APB word registers, 40 MHz pclk
// Notes: definitions only
`ifndef PLCT_DEFS_VH
`define PLCT_DEFS_VH
`define PLCT_OFS_CTRL 8'h00
`define PLCT_OFS_SET_LENGTH 8'h04
`define PLCT_OFS_PPM 8'h08
`define PLCT_OFS_FINAL 8'h0C
`define PLCT_OFS_INTER 8'h10
`define PLCT_OFS_TIMED 8'h14
`define PLCT_OFS_PON_LIMIT 8'h18
`define PLCT_OFS_RUN_LIMIT 8'h1C
`define PLCT_OFS_COUNT_MON 8'h20
`define PLCT_OFS_LENGTH_MON 8'h24
`define PLCT_OFS_REMAIN_MON 8'h28
`define PLCT_OFS_PON_HOURS 8'h2C
`define PLCT_OFS_RUN_HOURS 8'h30
`define PLCT_OFS_STATUS 8'h34
`define PLCT_OFS_IRQ_STATUS 8'h38
`define PLCT_OFS_IRQ_CLEAR 8'h3C
`define PLCT_OFS_IRQ_ENABLE 8'h40
`define PLCT_OFS_SW_CLEAR 8'h44
// ctrl fields
`define PLCT_CTRL_RUN 0
`define PLCT_CTRL_FAST_LO 1
`define PLCT_CTRL_FAST_HI 2
`define PLCT_CTRL_DEC_LO 3
`define PLCT_CTRL_DEC_HI 4
// fast terminal function codes
`define PLCT_FAST_NONE 2'h0
`define PLCT_FAST_COUNT 2'h1
`define PLCT_FAST_LENGTH 2'h2
// sw clear / event bit positions
`define PLCT_CLR_LENGTH 0
`define PLCT_CLR_COUNT 1
`define PLCT_CLR_TIMED 2
`define PLCT_EV_LENGTH 0
`define PLCT_EV_INTER 1
`define PLCT_EV_FINAL 2
`define PLCT_EV_TIME 3
`define PLCT_EV_LOCK 4
`define PLCT_EV_W 5
// reset values and write limits
`define PLCT_RST_SET_LENGTH 16'h03E8
`define PLCT_RST_PPM 16'h03E8
`define PLCT_RST_FINAL 16'h03E8
`define PLCT_RST_INTER 16'h03E8
`define PLCT_RST_TIMED 16'h0000
`define PLCT_PPM_MIN 16'h0001
`define PLCT_TIMED_MAX 16'hFDE8
// timing: base tick of 1 ms, 0.1 min and 1 h derived from it
`define PLCT_CLK_PERIOD_NS 25
`define PLCT_TICK_NS 1000000
`define PLCT_TICK_CYCLES (`PLCT_TICK_NS / `PLCT_CLK_PERIOD_NS)
`define PLCT_DECIMIN_MS 6000
`define PLCT_HOUR_DECIMIN 600
`endif

/* logic/plct_sync.v */
// Purpose: two-stage synchroniser with rising-edge pulse for terminal inputs
// Assumes: inputs asynchronous to pclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module plct_sync #(
   parameter W = 6
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] async_in,
   output reg [W-1:0] level,
   output reg [W-1:0] rise
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= {W{1'b0}};
         stage2 <= {W{1'b0}};
         level <= {W{1'b0}};
         rise <= {W{1'b0}};
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         level <= stage2;
         rise <= stage2 & ~level;
      end
   end
endmodule

/* logic/plct_top.v */
// Purpose: pulse length counter, two-target counter, timed run and hour lockout
// Assumes: APB slave, 40 MHz pclk, terminal pins asynchronous
// Notes: pulses per metre in 0.1 units, timed run in 0.1 min units
`timescale 1ns/1ps
`include "plct_defs.vh"
module plct_top #(
   parameter COUNT_W = 16,
   parameter LEN_W = 32,
   parameter TICK_CYCLES = `PLCT_TICK_CYCLES,
   parameter DECIMIN_TICKS = `PLCT_DECIMIN_MS,
   parameter HOUR_DECIMINS = `PLCT_HOUR_DECIMIN
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] digital_input_terminal,
   input wire fast_pulse_terminal,
   input wire length_clear_in,
   input wire counter_clear_in,
   input wire timed_clear_in,
   output reg length_reached,
   output reg inter_count_reached,
   output reg final_count_reached,
   output reg time_reached,
   output reg drive_run,
   output reg lockout,
   output reg irq
);
   // terminal bits: 0 length pulse, 1 count pulse, 2 fast, 3..5 clears
   wire [5:0] pin_level;
   wire [5:0] pin_rise;

   plct_sync #(.W(6)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({timed_clear_in, counter_clear_in, length_clear_in,
                 fast_pulse_terminal, digital_input_terminal}),
      .level(pin_level),
      .rise(pin_rise)
   );

   reg run_request;
   reg [1:0] fast_terminal_function_select;
   reg [1:0] length_decimal_select;
   reg [15:0] set_length;
   reg [15:0] pulses_per_metre;
   reg [15:0] final_count_target;
   reg [15:0] intermediate_count_target;
   reg [15:0] timed_run_duration;
   reg [15:0] poweron_hour_limit;
   reg [15:0] run_hour_limit;
   reg [COUNT_W-1:0] count_monitor;
   reg [LEN_W-1:0] length_monitor;
   reg [15:0] elapsed;
   reg [15:0] accumulated_poweron_hours;
   reg [15:0] accumulated_run_hours;
   reg [`PLCT_EV_W-1:0] irq_status;
   reg [`PLCT_EV_W-1:0] irq_enable;
   reg [2:0] sw_clear;
   reg [`PLCT_EV_W-1:0] ev_prev;

   function [15:0] dec_scale;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: dec_scale = 16'h000A;
            2'h1: dec_scale = 16'h0064;
            2'h2: dec_scale = 16'h03E8;
            default: dec_scale = 16'h2710;
         endcase
      end
   endfunction

   // apb: one wait state so read data and pready come from flops
   wire apb_access = psel & penable & ~pready;
   wire apb_wr = apb_access & pwrite;
   reg [31:0] next_rdata;
   reg addr_ok;
   reg [15:0] remain;

   always @* begin
      next_rdata = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         `PLCT_OFS_CTRL: next_rdata = {27'h000_0000, length_decimal_select,
                                       fast_terminal_function_select, run_request};
         `PLCT_OFS_SET_LENGTH: next_rdata = {16'h0000, set_length};
         `PLCT_OFS_PPM: next_rdata = {16'h0000, pulses_per_metre};
         `PLCT_OFS_FINAL: next_rdata = {16'h0000, final_count_target};
         `PLCT_OFS_INTER: next_rdata = {16'h0000, intermediate_count_target};
         `PLCT_OFS_TIMED: next_rdata = {16'h0000, timed_run_duration};
         `PLCT_OFS_PON_LIMIT: next_rdata = {16'h0000, poweron_hour_limit};
         `PLCT_OFS_RUN_LIMIT: next_rdata = {16'h0000, run_hour_limit};
         `PLCT_OFS_COUNT_MON: next_rdata = {{(32-COUNT_W){1'b0}}, count_monitor};
         `PLCT_OFS_LENGTH_MON: next_rdata = length_monitor;
         `PLCT_OFS_REMAIN_MON: next_rdata = {16'h0000, remain};
         `PLCT_OFS_PON_HOURS: next_rdata = {16'h0000, accumulated_poweron_hours};
         `PLCT_OFS_RUN_HOURS: next_rdata = {16'h0000, accumulated_run_hours};
         `PLCT_OFS_STATUS: next_rdata = {26'h000_0000, lockout, drive_run, time_reached,
                                         final_count_reached, inter_count_reached,
                                         length_reached};
         `PLCT_OFS_IRQ_STATUS: next_rdata = {27'h000_0000, irq_status};
         `PLCT_OFS_IRQ_CLEAR: next_rdata = 32'h0000_0000;
         `PLCT_OFS_IRQ_ENABLE: next_rdata = {27'h000_0000, irq_enable};
         `PLCT_OFS_SW_CLEAR: next_rdata = 32'h0000_0000;
         default: addr_ok = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_access;
         pslverr <= apb_access & ~addr_ok;
         prdata <= (apb_access & ~pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   wire apb_commit = psel & penable & pready & pwrite & ~pslverr;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_request <= 1'b0;
         fast_terminal_function_select <= `PLCT_FAST_NONE;
         length_decimal_select <= 2'h0;
         set_length <= `PLCT_RST_SET_LENGTH;
         pulses_per_metre <= `PLCT_RST_PPM;
         final_count_target <= `PLCT_RST_FINAL;
         intermediate_count_target <= `PLCT_RST_INTER;
         timed_run_duration <= `PLCT_RST_TIMED;
         poweron_hour_limit <= 16'h0000;
         run_hour_limit <= 16'h0000;
         irq_enable <= {`PLCT_EV_W{1'b0}};
         sw_clear <= 3'h0;
      end else begin
         sw_clear <= 3'h0;
         if (apb_commit) begin
            case (paddr)
               `PLCT_OFS_CTRL: begin
                  run_request <= pwdata[`PLCT_CTRL_RUN];
                  fast_terminal_function_select <= pwdata[`PLCT_CTRL_FAST_HI:`PLCT_CTRL_FAST_LO];
                  length_decimal_select <= pwdata[`PLCT_CTRL_DEC_HI:`PLCT_CTRL_DEC_LO];
               end
               `PLCT_OFS_SET_LENGTH: set_length <= pwdata[15:0];
               // zero would mean an infinite length, so it is raised to 0.1
               `PLCT_OFS_PPM: pulses_per_metre <= (pwdata[15:0] < `PLCT_PPM_MIN) ?
                                                  `PLCT_PPM_MIN : pwdata[15:0];
               `PLCT_OFS_FINAL: final_count_target <= pwdata[15:0];
               `PLCT_OFS_INTER: intermediate_count_target <= pwdata[15:0];
               `PLCT_OFS_TIMED: timed_run_duration <= (pwdata[15:0] > `PLCT_TIMED_MAX) ?
                                                      `PLCT_TIMED_MAX : pwdata[15:0];
               `PLCT_OFS_PON_LIMIT: poweron_hour_limit <= pwdata[15:0];
               `PLCT_OFS_RUN_LIMIT: run_hour_limit <= pwdata[15:0];
               `PLCT_OFS_IRQ_ENABLE: irq_enable <= pwdata[`PLCT_EV_W-1:0];
               `PLCT_OFS_SW_CLEAR: sw_clear <= pwdata[2:0];
               default: ;
            endcase
         end
      end
   end

   // pulse routing; the fast terminal takes over a function when selected
   wire len_pulse = (fast_terminal_function_select == `PLCT_FAST_LENGTH) ?
                    pin_rise[2] : pin_rise[0];
   wire cnt_pulse = (fast_terminal_function_select == `PLCT_FAST_COUNT) ?
                    pin_rise[2] : pin_rise[1];
   wire clr_len = pin_level[3] | sw_clear[`PLCT_CLR_LENGTH];
   wire clr_cnt = pin_level[4] | sw_clear[`PLCT_CLR_COUNT];
   wire clr_tim = pin_level[5] | sw_clear[`PLCT_CLR_TIMED];

   // length: N*10*10^d >= set*ppm, no divider needed
   wire [47:0] len_lhs = {{(48-LEN_W){1'b0}}, length_monitor} * {32'h0000_0000,
                         dec_scale(length_decimal_select)};
   // widen before multiplying; the product needs all 32 bits
   wire [31:0] len_prod = {16'h0000, set_length} * {16'h0000, pulses_per_metre};
   wire [47:0] len_rhs = {16'h0000, len_prod};
   wire next_length_reached = ~clr_len & (len_lhs >= len_rhs);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         length_monitor <= {LEN_W{1'b0}};
         length_reached <= 1'b0;
      end else begin
         length_reached <= next_length_reached;
         if (clr_len)
            length_monitor <= {LEN_W{1'b0}};
         else if (len_pulse && length_monitor != {LEN_W{1'b1}})
            length_monitor <= length_monitor + 1'b1;
      end
   end

   // counter; an intermediate above the final is held at the final
   wire cnt_enabled = (final_count_target != 16'h0000) |
                      (intermediate_count_target != 16'h0000);
   wire [15:0] inter_eff = (intermediate_count_target > final_count_target) ?
                           final_count_target : intermediate_count_target;
   wire [15:0] cnt_wide = {{(16-COUNT_W){1'b0}}, count_monitor};
   wire cnt_final = cnt_enabled & (cnt_wide >= final_count_target);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_monitor <= {COUNT_W{1'b0}};
         inter_count_reached <= 1'b0;
         final_count_reached <= 1'b0;
      end else begin
         inter_count_reached <= ~clr_cnt & cnt_enabled & (cnt_wide >= inter_eff);
         final_count_reached <= ~clr_cnt & cnt_final;
         if (clr_cnt)
            count_monitor <= {COUNT_W{1'b0}};
         else if (cnt_pulse && cnt_enabled && !cnt_final &&
                  count_monitor != {COUNT_W{1'b1}})
            count_monitor <= count_monitor + 1'b1;
      end
   end

   // time base: 1 ms tick, 0.1 min step, 1 h step
   reg [31:0] tick_div;
   reg [15:0] ms_div;
   reg [15:0] dm_pon_div;
   reg [15:0] dm_run_div;
   reg tick_ms;
   reg tick_dm;
   wire [31:0] tick_last = TICK_CYCLES - 1;
   wire [31:0] dm_full = DECIMIN_TICKS - 1;
   wire [31:0] hr_full = HOUR_DECIMINS - 1;
   wire [15:0] dm_last = dm_full[15:0];
   wire [15:0] hr_last = hr_full[15:0];

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_div <= 32'h0000_0000;
         ms_div <= 16'h0000;
         tick_ms <= 1'b0;
         tick_dm <= 1'b0;
      end else begin
         tick_ms <= (tick_div == tick_last);
         tick_div <= (tick_div == tick_last) ? 32'h0000_0000 : tick_div + 1'b1;
         tick_dm <= tick_ms & (ms_div == dm_last);
         if (tick_ms)
            ms_div <= (ms_div == dm_last) ? 16'h0000 : ms_div + 1'b1;
      end
   end

   wire timed_on = (timed_run_duration != 16'h0000);
   wire timed_hit = timed_on & drive_run & tick_dm & (elapsed + 1'b1 >= timed_run_duration);
   wire hit_pon = (poweron_hour_limit != 16'h0000) &
                  (accumulated_poweron_hours >= poweron_hour_limit);
   wire hit_run = (run_hour_limit != 16'h0000) &
                  (accumulated_run_hours >= run_hour_limit);
   wire next_lockout = hit_pon | hit_run;
   // time reached holds until the run request drops or it is cleared
   wire next_time_reached = ~clr_tim & run_request & (time_reached | timed_hit);
   wire next_drive_run = run_request & ~next_lockout & ~next_time_reached;

   always @* begin
      remain = timed_run_duration;
      if (drive_run)
         remain = timed_run_duration - elapsed;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed <= 16'h0000;
         time_reached <= 1'b0;
         drive_run <= 1'b0;
         lockout <= 1'b0;
         dm_pon_div <= 16'h0000;
         dm_run_div <= 16'h0000;
         accumulated_poweron_hours <= 16'h0000;
         accumulated_run_hours <= 16'h0000;
      end else begin
         time_reached <= next_time_reached;
         drive_run <= next_drive_run;
         lockout <= next_lockout;
         if (!drive_run || clr_tim)
            elapsed <= 16'h0000;
         else if (tick_dm && timed_on && elapsed != 16'hFFFF)
            elapsed <= elapsed + 1'b1;
         if (tick_dm) begin
            dm_pon_div <= (dm_pon_div == hr_last) ? 16'h0000 : dm_pon_div + 1'b1;
            if (dm_pon_div == hr_last && accumulated_poweron_hours != 16'hFFFF)
               accumulated_poweron_hours <= accumulated_poweron_hours + 1'b1;
            if (drive_run) begin
               dm_run_div <= (dm_run_div == hr_last) ? 16'h0000 : dm_run_div + 1'b1;
               if (dm_run_div == hr_last && accumulated_run_hours != 16'hFFFF)
                  accumulated_run_hours <= accumulated_run_hours + 1'b1;
            end
         end
      end
   end

   // interrupts: rising edge of each flag, set beats clear
   wire [`PLCT_EV_W-1:0] ev_now = {lockout, time_reached, final_count_reached,
                                   inter_count_reached, length_reached};
   wire [`PLCT_EV_W-1:0] ev_set = ev_now & ~ev_prev;
   wire [`PLCT_EV_W-1:0] ev_clr = (apb_commit && paddr == `PLCT_OFS_IRQ_CLEAR) ?
                                  pwdata[`PLCT_EV_W-1:0] : {`PLCT_EV_W{1'b0}};
   wire [`PLCT_EV_W-1:0] next_irq_status = ev_set | (irq_status & ~ev_clr);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_prev <= {`PLCT_EV_W{1'b0}};
         irq_status <= {`PLCT_EV_W{1'b0}};
         irq <= 1'b0;
      end else begin
         ev_prev <= ev_now;
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_enable);
      end
   end
endmodule

/* verification/plct_monitor.sv */
// Purpose: port-level assertions for plct_top
// Assumes: one clock, presetn async active low
// Notes: clear inputs are held at least 8 cycles by the bench
`timescale 1ns/1ps
module plct_monitor (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pready,
   input logic pslverr,
   input logic length_clear_in,
   input logic counter_clear_in,
   input logic timed_clear_in,
   input logic length_reached,
   input logic inter_count_reached,
   input logic final_count_reached,
   input logic time_reached,
   input logic drive_run,
   input logic lockout
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_one_wait: assert property (s_access |=> s_answer)
      else $error("pready not one cycle after access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   a_final_inter: assert property (final_count_reached |-> inter_count_reached)
      else $error("final flag without intermediate flag");
   a_final_holds: assert property (final_count_reached && !counter_clear_in |=> final_count_reached)
      else $error("final flag dropped without clear");
   a_count_clear: assert property (counter_clear_in [*8] |-> !inter_count_reached && !final_count_reached)
      else $error("count flags survive clear");
   a_len_clear: assert property (length_clear_in [*8] |-> !length_reached)
      else $error("length flag survives clear");
   a_time_clear: assert property (timed_clear_in [*8] |-> !time_reached)
      else $error("time flag survives clear");
   a_time_stops: assert property (time_reached [*2] |-> !drive_run)
      else $error("drive runs after time reached");
   a_lock_stops: assert property (lockout [*2] |-> !drive_run)
      else $error("drive runs while locked");
endmodule
bind plct_top plct_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .length_clear_in, .counter_clear_in, .timed_clear_in, .length_reached,
   .inter_count_reached, .final_count_reached, .time_reached, .drive_run, .lockout);

/* verification/plct_pulse_src.sv */
// Purpose: pulse sensor model on the two terminals and the fast terminal
// Assumes: pins[0] length, pins[1] count, pins[2] fast
// Notes: pulses far above the terminal filter rate; design filter is not modelled
`timescale 1ns/1ps
module plct_pulse_src (
   input wire logic pclk,
   output logic [2:0] pins
);
   initial pins = 3'b000;
   // only one pin pulses per call, never two terminals at once
   task automatic send(input int sel, input int n);
      repeat (n) begin
         @(posedge pclk);
         pins[sel] <= 1'b1;
         repeat (3) @(posedge pclk);
         pins[sel] <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask
endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench for plct_top
// Assumes: short tick parameters, APB master in bench
// Notes: reads are queued and checked by the monitor process
`timescale 1ns/1ps
`include "plct_defs.vh"
module tb_top;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, len_r, int_r, fin_r, tim_r, run_o, lock_o, irq;
   logic [2:0] pins;
   logic [2:0] clrs = 3'b000;
   logic [32:0] exp_q[$];
   int fails = 0;
   int check_count = 0;
   int seed = 75;
   int n, i;
   always #12.5 pclk = ~pclk;
   plct_top #(.TICK_CYCLES(4), .DECIMIN_TICKS(2), .HOUR_DECIMINS(2)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .digital_input_terminal(pins[1:0]), .fast_pulse_terminal(pins[2]),
      .length_clear_in(clrs[0]), .counter_clear_in(clrs[1]), .timed_clear_in(clrs[2]),
      .length_reached(len_r), .inter_count_reached(int_r), .final_count_reached(fin_r),
      .time_reached(tim_r), .drive_run(run_o), .lockout(lock_o), .irq(irq));
   plct_pulse_src src (.pclk(pclk), .pins(pins));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED apb_read exp %h got %h", e, g);
      end
   endtask
   task automatic cmp_pin(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %b got %b", nm, e, g);
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         cmp_rd(exp_q.pop_front(), {pslverr, prdata});
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
      exp_q.push_back({err, e});
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // clears act on level, so hold well past the synchroniser
   task automatic pulse_clr(input int b);
      @(posedge pclk);
      clrs[b] <= 1'b1;
      repeat (10) @(posedge pclk);
      clrs[b] <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask
   initial begin
      #(25 * 20000);
      fails++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`PLCT_OFS_SET_LENGTH, 32'h0000_03e8);
      rd(`PLCT_OFS_PPM, 32'h0000_03e8);
      rd(`PLCT_OFS_FINAL, 32'h0000_03e8);
      rd(`PLCT_OFS_TIMED, 32'h0000_0000);
      rd(8'h80, 32'h0000_0000, 1'b1);
      wr(`PLCT_OFS_PPM, 32'h0000_0000);
      rd(`PLCT_OFS_PPM, 32'h0000_0001);
      wr(`PLCT_OFS_FINAL, 32'h0000_0008);
      wr(`PLCT_OFS_INTER, 32'h0000_0005);
      src.send(1, 5);
      rd(`PLCT_OFS_STATUS, 32'h0000_0002);
      rd(`PLCT_OFS_IRQ_STATUS, 32'h0000_0002);
      cmp_pin("irq_masked", 1'b0, irq);
      wr(`PLCT_OFS_IRQ_ENABLE, 32'h0000_0002);
      repeat (3) @(negedge pclk);
      cmp_pin("irq", 1'b1, irq);
      wr(`PLCT_OFS_IRQ_CLEAR, 32'h0000_0002);
      repeat (3) @(negedge pclk);
      cmp_pin("irq_clr", 1'b0, irq);
      rd(`PLCT_OFS_IRQ_STATUS, 32'h0000_0000);
      n = 4 + ($unsigned($random(seed)) % 3);
      src.send(1, n);
      rd(`PLCT_OFS_STATUS, 32'h0000_0006);
      rd(`PLCT_OFS_COUNT_MON, 32'h0000_0008);
      pulse_clr(1);
      rd(`PLCT_OFS_COUNT_MON, 32'h0000_0000);
      rd(`PLCT_OFS_STATUS, 32'h0000_0000);
      wr(`PLCT_OFS_SET_LENGTH, 32'h0000_0002);
      wr(`PLCT_OFS_PPM, 32'h0000_0028);
      src.send(0, 7);
      rd(`PLCT_OFS_STATUS, 32'h0000_0000);
      src.send(0, 1);
      rd(`PLCT_OFS_STATUS, 32'h0000_0001);
      rd(`PLCT_OFS_LENGTH_MON, 32'h0000_0008);
      pulse_clr(0);
      rd(`PLCT_OFS_LENGTH_MON, 32'h0000_0000);
      rd(`PLCT_OFS_STATUS, 32'h0000_0000);
      wr(`PLCT_OFS_CTRL, 32'h0000_0008);
      src.send(0, 1);
      rd(`PLCT_OFS_STATUS, 32'h0000_0001);
      pulse_clr(0);
      // product of 65536 must not wrap to zero
      wr(`PLCT_OFS_SET_LENGTH, 32'h0000_1000);
      wr(`PLCT_OFS_PPM, 32'h0000_0010);
      rd(`PLCT_OFS_STATUS, 32'h0000_0000);
      wr(`PLCT_OFS_CTRL, 32'h0000_0002);
      src.send(2, 2);
      rd(`PLCT_OFS_COUNT_MON, 32'h0000_0002);
      wr(`PLCT_OFS_CTRL, 32'h0000_0000);
      pulse_clr(1);
      // inter first, so final >= inter holds at every step
      wr(`PLCT_OFS_INTER, 32'h0000_0000);
      wr(`PLCT_OFS_FINAL, 32'h0000_0000);
      src.send(1, 3);
      rd(`PLCT_OFS_COUNT_MON, 32'h0000_0000);
      wr(`PLCT_OFS_TIMED, 32'h0000_0003);
      rd(`PLCT_OFS_REMAIN_MON, 32'h0000_0003);
      wr(`PLCT_OFS_CTRL, 32'h0000_0001);
      repeat (3) @(negedge pclk);
      cmp_pin("drive_run", 1'b1, run_o);
      n = 3;
      while (tim_r !== 1'b1 && n < 80) begin
         @(negedge pclk);
         n++;
      end
      // 0.3 min is 24 cycles with the short ticks
      cmp_pin("time_span", 1'b1, n >= 16 && n < 40);
      cmp_pin("drive_stop", 1'b0, run_o);
      pulse_clr(2);
      cmp_pin("time_clr", 1'b0, tim_r);
      wr(`PLCT_OFS_CTRL, 32'h0000_0000);
      rd(`PLCT_OFS_REMAIN_MON, 32'h0000_0003);
      wr(`PLCT_OFS_TIMED, 32'h0000_0000);
      wr(`PLCT_OFS_CTRL, 32'h0000_0001);
      for (i = 0; i < 2; i++) begin
         wr(i ? `PLCT_OFS_RUN_LIMIT : `PLCT_OFS_PON_LIMIT, 32'h0000_0001);
         repeat (8) @(negedge pclk);
         cmp_pin("lockout", 1'b1, lock_o);
         cmp_pin("lock_run", 1'b0, run_o);
         wr(i ? `PLCT_OFS_RUN_LIMIT : `PLCT_OFS_PON_LIMIT, 32'h0000_0000);
         repeat (8) @(negedge pclk);
         cmp_pin("unlock", 1'b0, lock_o);
      end
      cmp_pin("timed_off", 1'b0, tim_r);
      finish_test();
   end
endmodule
